// *** verilog/dpmu_param_update.sv ***
/*
 * Parameter and program memory access for the DSP core: boot default load,
 * direct host access, soft shutdown with volume ramps, and safeload copies.
 * Assumes a register master on the plain strobe port, synchronous to i_clk,
 * and a DSP core that reports when it is using the parameter memory.
 */
`include "dpmu_params.svh"

module dpmu_param_update #(
  parameter int unsigned RAMP_CYC = `DPMU_RAMP_TIME_NS / `DPMU_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic                           i_clk,
  input  wire logic                           i_rst_n,
  // register port
  input  wire dpmu_pkg::dpmu_bus_t            i_bus,
  output logic [31:0]                         o_rdata,
  // dsp core side
  input  wire logic                           i_core_busy,
  input  wire logic [`DPMU_PARAM_AW-1:0]      i_core_caddr,
  input  wire logic [`DPMU_PROG_AW-1:0]       i_core_pc,
  output logic [`DPMU_PARAM_WIDTH-1:0]        o_core_coef,
  output logic [`DPMU_PROG_WIDTH-1:0]         o_core_instr,
  output logic                                o_core_run,
  output logic                                o_ramp_dn,
  output logic                                o_ramp_up,
  // interrupt
  output logic                                o_irq
);

  localparam logic [31:0] RAMP_LAST = 32'(RAMP_CYC - 1);

  dpmu_pkg::dpmu_regs_t q;
  dpmu_pkg::dpmu_regs_t d;

  logic [`DPMU_PARAM_WIDTH-1:0] pmem [`DPMU_PARAM_DEPTH];
  logic [`DPMU_PROG_WIDTH-1:0]  prog [`DPMU_PROG_DEPTH];

  logic                         pm_we;
  logic [`DPMU_PARAM_AW-1:0]    pm_wa;
  logic [`DPMU_PARAM_WIDTH-1:0] pm_wd;
  logic                         prog_we;
  logic [`DPMU_PROG_AW-1:0]     prog_wa;
  logic [`DPMU_PROG_WIDTH-1:0]  prog_wd;
  logic                         sl_copy;
  logic                         sl_set;
  logic                         shut_set;
  logic                         safe_req;
  logic [2:0]                   sl_idx;
  logic [`DPMU_MADDR_WIDTH-1:0] addr_inc;

  // ---------------------------------------------------------------------------
  // boot table and safeload priority
  // ---------------------------------------------------------------------------
  function automatic logic [`DPMU_PARAM_WIDTH-1:0] boot_word(input logic [7:0] a);
    logic [`DPMU_PARAM_WIDTH-1:0] w;
    w = 22'h000000;
    if (a < `DPMU_BIQUAD_WORDS && (a % `DPMU_BIQUAD_LEN) == 8'h00) begin
      w = `DPMU_ONE;
    end else if ((a >= `DPMU_MAIN_LUT_LO && a <= `DPMU_MAIN_LUT_HI) ||
                 (a >= `DPMU_SUB_LUT_LO && a <= `DPMU_SUB_LUT_HI)) begin
      w = `DPMU_ONE;
    end else if (a == `DPMU_MAIN_POST || a == `DPMU_SUB_POST) begin
      w = `DPMU_ONE;
    end else if (a == `DPMU_MAIN_ATTACK || a == `DPMU_SUB_ATTACK) begin
      w = `DPMU_ATTACK;
    end else if (a == `DPMU_SUB_GAIN_L || a == `DPMU_SUB_GAIN_R) begin
      w = `DPMU_HALF;
    end else if (a == `DPMU_MAIN_DECAY || a == `DPMU_SUB_DECAY) begin
      w = `DPMU_DECAY;
    end
    return w;
  endfunction

  function automatic logic [2:0] lowest_pend(input logic [`DPMU_SL_ENTRIES-1:0] p);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = `DPMU_SL_ENTRIES - 1; i >= 0; i--) begin
      if (p[i]) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  // ---------------------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------------------
  always_comb begin
    d        = q;
    pm_we    = 1'b0;
    pm_wa    = '0;
    pm_wd    = '0;
    prog_we  = 1'b0;
    prog_wa  = '0;
    prog_wd  = '0;
    sl_copy  = 1'b0;
    sl_set   = 1'b0;
    shut_set = 1'b0;
    sl_idx   = lowest_pend(q.sl_pend);
    safe_req = i_bus.wr && i_bus.addr == `DPMU_REG_CTRL && i_bus.wdata[`DPMU_CTRL_SAFE_BIT];
    addr_inc = {q.mem_addr[`DPMU_MADDR_PROG_BIT], q.mem_addr[`DPMU_PROG_AW-1:0] + 10'h001};

    // host register writes
    if (i_bus.wr) begin
      unique case (i_bus.addr)
        `DPMU_REG_CTRL:     d.halt = i_bus.wdata[`DPMU_CTRL_HALT_BIT];
        `DPMU_REG_MADDR:    d.mem_addr = i_bus.wdata[`DPMU_MADDR_WIDTH-1:0];
        `DPMU_REG_IRQ_MASK: d.irq_mask = i_bus.wdata[1:0];
        `DPMU_REG_MDATA: begin
          // direct program access is allowed in every core state, parameter writes in all but boot
          if (q.mem_addr[`DPMU_MADDR_PROG_BIT]) begin
            prog_we = 1'b1;
            prog_wa = q.mem_addr[`DPMU_PROG_AW-1:0];
            prog_wd = i_bus.wdata;
          end else begin
            pm_we = 1'b1;
            pm_wa = q.mem_addr[`DPMU_PARAM_AW-1:0];
            pm_wd = i_bus.wdata[`DPMU_PARAM_WIDTH-1:0];
          end
          d.mem_addr = addr_inc;
        end
        default: ;
      endcase
    end
    if (i_bus.rd && i_bus.addr == `DPMU_REG_MDATA) begin
      d.mem_addr = addr_inc;
    end

    // safeload copy: one entry a cycle while the memory is idle
    if (q.sl_busy) begin
      if (q.sl_pend == '0) begin
        d.sl_busy = 1'b0;
        sl_set    = 1'b1;
      end else if (!i_core_busy && !pm_we && !prog_we && q.st != dpmu_pkg::DPMU_BOOT) begin
        sl_copy = 1'b1;
        pm_we   = 1'b1;
        pm_wa   = q.sl_addr[sl_idx];
        pm_wd   = q.sl_data[sl_idx];
        d.sl_pend[sl_idx] = 1'b0;
      end
    end else if (safe_req) begin
      d.sl_busy = 1'b1;
    end

    // holding register writes; data write marks the entry pending
    for (int i = 0; i < `DPMU_SL_ENTRIES; i++) begin
      if (i_bus.wr && i_bus.addr == `DPMU_REG_SL_BASE + 8'(2 * i)) begin
        d.sl_addr[i] = i_bus.wdata[`DPMU_PARAM_AW-1:0];
      end
      if (i_bus.wr && i_bus.addr == `DPMU_REG_SL_BASE + 8'(2 * i + 1)) begin
        d.sl_data[i] = i_bus.wdata[`DPMU_PARAM_WIDTH-1:0];
        d.sl_pend[i] = 1'b1;
      end
    end

    // core state and volume ramps
    d.ramp_cnt = q.ramp_cnt + 32'h00000001;
    unique case (q.st)
      dpmu_pkg::DPMU_BOOT: begin
        // boot load wins the port; host parameter writes here are lost
        pm_we       = 1'b1;
        pm_wa       = q.boot_addr[7:0];
        pm_wd       = boot_word(q.boot_addr[7:0]);
        d.boot_addr = q.boot_addr + 9'h001;
        if (q.boot_addr == 9'h0ff) begin
          d.st = dpmu_pkg::DPMU_RUN;
        end
      end
      dpmu_pkg::DPMU_RUN: begin
        if (q.halt) begin
          d.st       = dpmu_pkg::DPMU_RAMP_DN;
          d.ramp_cnt = '0;
        end
      end
      dpmu_pkg::DPMU_RAMP_DN: begin
        if (!q.halt) begin
          d.st       = dpmu_pkg::DPMU_RAMP_UP;
          d.ramp_cnt = '0;
        end else if (q.ramp_cnt == RAMP_LAST) begin
          d.st     = dpmu_pkg::DPMU_HALTED;
          shut_set = 1'b1;
        end
      end
      dpmu_pkg::DPMU_HALTED: begin
        if (!q.halt) begin
          d.st       = dpmu_pkg::DPMU_RAMP_UP;
          d.ramp_cnt = '0;
        end
      end
      dpmu_pkg::DPMU_RAMP_UP: begin
        if (q.halt) begin
          d.st       = dpmu_pkg::DPMU_RAMP_DN;
          d.ramp_cnt = '0;
        end else if (q.ramp_cnt == RAMP_LAST) begin
          d.st = dpmu_pkg::DPMU_RUN;
        end
      end
      default: d.st = dpmu_pkg::DPMU_BOOT;
    endcase
    d.shut_done = d.st == dpmu_pkg::DPMU_HALTED;

    // sticky flags: the read clear comes first so a same-cycle set survives
    if (i_bus.rd && i_bus.addr == `DPMU_REG_STAT) begin
      d.sl_done = 1'b0;
    end
    if (sl_set) begin
      d.sl_done = 1'b1;
    end
    if (i_bus.rd && i_bus.addr == `DPMU_REG_IRQ_STAT) begin
      d.irq_stat = 2'h0;
    end
    d.irq_stat = d.irq_stat | {shut_set, sl_set};

    // read data, valid the cycle after the strobe
    d.rdata = 32'h00000000;
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        `DPMU_REG_CTRL:     d.rdata = 32'(q.halt) << `DPMU_CTRL_HALT_BIT;
        `DPMU_REG_STAT:     d.rdata = {30'h0, q.shut_done, q.sl_done};
        `DPMU_REG_MADDR:    d.rdata = 32'(q.mem_addr);
        `DPMU_REG_IRQ_STAT: d.rdata = {30'h0, q.irq_stat};
        `DPMU_REG_IRQ_MASK: d.rdata = {30'h0, q.irq_mask};
        `DPMU_REG_MDATA: begin
          if (q.mem_addr[`DPMU_MADDR_PROG_BIT]) begin
            d.rdata = prog[q.mem_addr[`DPMU_PROG_AW-1:0]];
          end else begin
            d.rdata = 32'(pmem[q.mem_addr[`DPMU_PARAM_AW-1:0]]);
          end
        end
        default: begin
          for (int i = 0; i < `DPMU_SL_ENTRIES; i++) begin
            if (i_bus.addr == `DPMU_REG_SL_BASE + 8'(2 * i)) begin
              d.rdata = 32'(q.sl_addr[i]);
            end
            if (i_bus.addr == `DPMU_REG_SL_BASE + 8'(2 * i + 1)) begin
              d.rdata = 32'(q.sl_data[i]);
            end
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      q    <= '0;
      q.st <= dpmu_pkg::DPMU_BOOT;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------------------
  // memories; arrays carry no reset, the boot load fills the parameters
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (pm_we) begin
      pmem[pm_wa] <= pm_wd;
    end
    if (prog_we) begin
      prog[prog_wa] <= prog_wd;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_core_coef  <= '0;
      o_core_instr <= '0;
    end else begin
      o_core_coef  <= pmem[i_core_caddr];
      o_core_instr <= prog[i_core_pc];
    end
  end

  assign o_rdata    = q.rdata;
  assign o_core_run = q.st inside {dpmu_pkg::DPMU_RUN, dpmu_pkg::DPMU_RAMP_DN,
                                   dpmu_pkg::DPMU_RAMP_UP};
  assign o_ramp_dn  = q.st == dpmu_pkg::DPMU_RAMP_DN;
  assign o_ramp_up  = q.st == dpmu_pkg::DPMU_RAMP_UP;
  assign o_irq      = |(q.irq_stat & q.irq_mask);

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_boot_last;
    q.st == dpmu_pkg::DPMU_BOOT && q.boot_addr == 9'h0ff;
  endsequence
  sequence s_ramp_end;
    q.st == dpmu_pkg::DPMU_RAMP_DN && q.halt && q.ramp_cnt == RAMP_LAST;
  endsequence

  boot_finish_a: assert property (s_boot_last |=> q.st == dpmu_pkg::DPMU_RUN)
    else $error("boot load did not hand over to run");
  boot_biquad_a: assert property (q.st == dpmu_pkg::DPMU_BOOT && q.boot_addr < 9'd110 &&
    (q.boot_addr % 9'd5) == 9'd0 |-> pm_we && pm_wd == `DPMU_ONE)
    else $error("biquad b0 default is not unity");
  boot_table_a: assert property (q.st == dpmu_pkg::DPMU_BOOT && q.boot_addr >= 9'd145 &&
    q.boot_addr <= 9'd177 |-> pm_wd == `DPMU_ONE && pm_wa == q.boot_addr[7:0])
    else $error("compressor table default is not unity");
  halt_stop_a: assert property (s_ramp_end |=> q.st == dpmu_pkg::DPMU_HALTED ##1
    (q.shut_done && !o_core_run) or !q.halt)
    else $error("core did not stop after ramp-down");
  halt_flag_a: assert property ($rose(q.st == dpmu_pkg::DPMU_HALTED) |->
    $past(q.st) == dpmu_pkg::DPMU_RAMP_DN && $past(q.ramp_cnt) == RAMP_LAST &&
    q.shut_done)
    else $error("shutdown complete set before ramp ended");
  core_restart_a: assert property (q.st == dpmu_pkg::DPMU_HALTED && !q.halt |=>
    o_ramp_up && q.ramp_cnt == 32'h0 ##1 o_core_run)
    else $error("clearing halt did not start ramp-up");
  burst_inc_a: assert property (i_bus.wr && i_bus.addr == `DPMU_REG_MDATA |=>
    q.mem_addr[9:0] == $past(q.mem_addr[9:0]) + 10'h001)
    else $error("memory address did not advance");
  sl_progress_a: assert property (sl_copy |=>
    $countones(q.sl_pend) < $countones($past(q.sl_pend)) ||
    $past(i_bus.wr))
    else $error("safeload copy left its entry pending");
  sl_target_a: assert property (sl_copy |-> pm_we && !prog_we &&
    pm_wa == q.sl_addr[sl_idx])
    else $error("safeload wrote outside parameter memory");
  sl_frame_a: assert property (safe_req && !q.sl_busy && !i_bus.rd ##1
    (!i_core_busy && !i_bus.wr && !i_bus.rd) [*7] |-> q.sl_done)
    else $error("idle safeload copy took more than seven cycles");
  sl_done_a: assert property (q.sl_busy && q.sl_pend == '0 |=>
    q.sl_done && !q.sl_busy ##1 (q.sl_done || $past(i_bus.rd)))
    else $error("safeload complete flag not held");
  sl_rdclr_a: assert property (i_bus.rd && i_bus.addr == `DPMU_REG_STAT && !sl_set |=>
    !q.sl_done && o_rdata[`DPMU_STAT_SL_BIT] == $past(q.sl_done))
    else $error("safeload complete not cleared by read");

endmodule // dpmu_param_update

// *** verilog/dpmu_params.svh ***
/*
 * Constants of the DSP parameter memory update block: memory shapes,
 * register offsets, bit positions, boot defaults and shutdown ramp timing.
 * Assumes inclusion by bare name from the package and the design file.
 */
`ifndef DPMU_PARAMS_SVH
`define DPMU_PARAMS_SVH

// ---------------------------------------------------------------------------
// memories and safeload holding registers
// ---------------------------------------------------------------------------
`define DPMU_PARAM_WIDTH   22
`define DPMU_PARAM_AW      8
`define DPMU_PARAM_DEPTH   256
`define DPMU_PROG_WIDTH    32
`define DPMU_PROG_AW       10
`define DPMU_PROG_DEPTH    1024
`define DPMU_SL_ENTRIES    5

// ---------------------------------------------------------------------------
// register offsets and fields
// ---------------------------------------------------------------------------
`define DPMU_REG_CTRL      8'h00
`define DPMU_REG_STAT      8'h01
`define DPMU_REG_MADDR     8'h02
`define DPMU_REG_MDATA     8'h03
`define DPMU_REG_IRQ_STAT  8'h04
`define DPMU_REG_IRQ_MASK  8'h05
`define DPMU_REG_SL_BASE   8'h10
`define DPMU_CTRL_SAFE_BIT 9
`define DPMU_CTRL_HALT_BIT 10
`define DPMU_STAT_SL_BIT   0
`define DPMU_STAT_SHUT_BIT 1
`define DPMU_MADDR_PROG_BIT 10
`define DPMU_MADDR_WIDTH   11

// ---------------------------------------------------------------------------
// boot defaults, 2.20 fractional format
// ---------------------------------------------------------------------------
`define DPMU_ONE           22'h100000
`define DPMU_HALF          22'h080000
`define DPMU_ATTACK        22'h00025b
`define DPMU_DECAY         22'h011d21
`define DPMU_BIQUAD_WORDS  8'd110
`define DPMU_BIQUAD_LEN    8'd5
`define DPMU_MAIN_LUT_LO   8'd110
`define DPMU_MAIN_LUT_HI   8'd142
`define DPMU_SUB_LUT_LO    8'd145
`define DPMU_SUB_LUT_HI    8'd177
`define DPMU_MAIN_ATTACK   8'd143
`define DPMU_MAIN_POST     8'd144
`define DPMU_SUB_ATTACK    8'd178
`define DPMU_SUB_POST      8'd179
`define DPMU_SUB_GAIN_L    8'd189
`define DPMU_SUB_GAIN_R    8'd190
`define DPMU_MAIN_DECAY    8'd193
`define DPMU_SUB_DECAY     8'd194

// ---------------------------------------------------------------------------
// timing
// ---------------------------------------------------------------------------
`define DPMU_CLK_PERIOD_NS 25
`define DPMU_RAMP_TIME_NS  15000000

`endif

// *** verilog/dpmu_pkg.sv ***
/*
 * Types of the DSP parameter memory update block: core states, register
 * bus request and the packed state of the block.
 * Assumes dpmu_params.svh on the include path.
 */
`include "dpmu_params.svh"

package dpmu_pkg;

  typedef enum logic [4:0] {
    DPMU_BOOT    = 5'h01,
    DPMU_RUN     = 5'h02,
    DPMU_RAMP_DN = 5'h04,
    DPMU_HALTED  = 5'h08,
    DPMU_RAMP_UP = 5'h10
  } dpmu_state_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } dpmu_bus_t;

  typedef struct packed {
    dpmu_state_t                                              st;
    logic [8:0]                                               boot_addr;
    logic [31:0]                                              ramp_cnt;
    logic                                                     halt;
    logic                                                     shut_done;
    logic                                                     sl_done;
    logic                                                     sl_busy;
    logic [`DPMU_SL_ENTRIES-1:0]                              sl_pend;
    logic [`DPMU_SL_ENTRIES-1:0][`DPMU_PARAM_AW-1:0]          sl_addr;
    logic [`DPMU_SL_ENTRIES-1:0][`DPMU_PARAM_WIDTH-1:0]       sl_data;
    logic [`DPMU_MADDR_WIDTH-1:0]                             mem_addr;
    logic [1:0]                                               irq_stat;
    logic [1:0]                                               irq_mask;
    logic [31:0]                                              rdata;
  } dpmu_regs_t;

endpackage

// *** testbench/dpmu_core_model.sv ***
/*
 * Behavioural DSP core for the parameter memory update bench: sweeps
 * coefficient and program addresses and reports memory use on command.
 * Assumes the bench drives i_hold right after a rising clock edge.
 */
module dpmu_core_model (
  // clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  // bench command
  input  wire logic       i_hold,
  // core side of the block
  output logic            o_busy,
  output logic [7:0]      o_caddr,
  output logic [9:0]      o_pc
);
  timeunit 1ns;
  timeprecision 1ps;
  // fetch never pauses; busy follows the bench so a safeload can be held off
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_busy  <= 1'b0;
      o_caddr <= 8'h00;
      o_pc    <= 10'h000;
    end else begin
      o_busy  <= i_hold;
      o_caddr <= o_caddr + 8'h01;
      o_pc    <= o_pc + 10'h001;
    end
  end
endmodule // dpmu_core_model

// *** testbench/tb_top.sv ***
/*
 * Self-checking bench of the parameter memory update block: boot defaults,
 * direct and burst access, safeload, soft shutdown and interrupt.
 * Assumes the design files and the core model are compiled before it.
 */
`include "dpmu_params.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned RAMP = 8;
  logic                i_clk, i_rst_n, hold, busy, run, rdn, rup, irq;
  dpmu_pkg::dpmu_bus_t bus;
  logic [31:0]         rdata, instr, r, seed = 32'h12a5;
  logic [21:0]         coef, pm [256], sd [5];
  logic [31:0]         pg [1024];
  logic [7:0]          caddr, sa [5];
  logic [9:0]          pc;
  logic [4:0]          pend;
  logic [10:0]         pb;
  int                  err_total = 0, cmp_count = 0, n;

  dpmu_param_update #(.RAMP_CYC(RAMP)) u_dpmu_param_update (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_bus(bus), .o_rdata(rdata),
    .i_core_busy(busy), .i_core_caddr(caddr), .i_core_pc(pc), .o_core_coef(coef),
    .o_core_instr(instr), .o_core_run(run), .o_ramp_dn(rdn), .o_ramp_up(rup), .o_irq(irq));
  dpmu_core_model u_dpmu_core_model (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_hold(hold), .o_busy(busy), .o_caddr(caddr),
    .o_pc(pc));

  initial begin
    i_clk = 1'b0;
    forever #12.5 i_clk = ~i_clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [21:0] boot_val(int a);
    if (a < 110) return (a % 5 == 0) ? `DPMU_ONE : 22'h0;
    if (a <= 142 || (a >= 145 && a <= 177) || a == 144 || a == 179) return `DPMU_ONE;
    if (a == 143 || a == 178) return `DPMU_ATTACK;
    if (a == 189 || a == 190) return `DPMU_HALF;
    if (a == 193 || a == 194) return `DPMU_DECAY;
    return 22'h0;
  endfunction

  task automatic print_verdict();
    $display("mismatches %0d comparisons %0d", err_total, cmp_count);
    if (err_total == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic fail_wait(input string what);
    err_total++;
    $display("[ERR] %0t wait bound ran out: %s", $time, what);
    print_verdict();
  endtask

  // ----------------------------------------------------------------------
  // register port master
  // ----------------------------------------------------------------------
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_clk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk);
    bus.rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus_rd(a, d);
    chk(d, exp, "register read");
  endtask

  // ----------------------------------------------------------------------
  // memory and safeload helpers, model kept in pm, pg and the holding arrays
  // ----------------------------------------------------------------------
  task automatic mem_wr(input logic [10:0] a, input int cnt);
    logic [31:0] d;
    bus_wr(`DPMU_REG_MADDR, {21'h0, a});
    for (int i = 0; i < cnt; i++) begin
      d = rnd();
      if (a[10]) pg[10'(a[9:0] + i)] = d;
      else begin
        d[31:22] = '0;
        pm[8'(a[7:0] + i)] = d[21:0];
      end
      bus_wr(`DPMU_REG_MDATA, d);
    end
  endtask
  task automatic mem_chk(input logic [10:0] a, input int cnt);
    logic [31:0] d;
    bus_wr(`DPMU_REG_MADDR, {21'h0, a});
    for (int i = 0; i < cnt; i++) begin
      bus_rd(`DPMU_REG_MDATA, d);
      chk(d, a[10] ? pg[10'(a[9:0] + i)] : {10'h0, pm[8'(a[7:0] + i)]}, "memory word");
    end
  endtask
  task automatic sl_set(input int i, input logic [7:0] a, input logic [21:0] d);
    bus_wr(8'(`DPMU_REG_SL_BASE + 2 * i), {24'h0, a});
    bus_wr(8'(`DPMU_REG_SL_BASE + 2 * i + 1), {10'h0, d});
    pend[i] = 1'b1;
    sa[i] = a;
    sd[i] = d;
  endtask
  task automatic sl_req();
    bus_wr(`DPMU_REG_CTRL, 32'h1 << `DPMU_CTRL_SAFE_BIT);
    for (int i = 0; i < 5; i++) if (pend[i]) pm[sa[i]] = sd[i];
    pend = '0;
  endtask
  task automatic sl_wait(output int cnt);
    logic [31:0] d;
    d = '0;
    for (cnt = 0; d[`DPMU_STAT_SL_BIT] !== 1'b1; cnt++) begin
      if (cnt == 40) fail_wait("safeload");
      bus_rd(`DPMU_REG_STAT, d);
    end
  endtask
  // sel 0 watches core run, sel 1 the ramp-up flag
  task automatic wait_for(input int sel, input logic v, input int lim, output int cnt);
    for (cnt = 0; cnt < lim; cnt++) begin
      @(posedge i_clk);
      #1;
      if ((sel == 0 ? run : rup) === v) return;
    end
    fail_wait("level");
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    i_rst_n = 1'b0;
    hold = 1'b0;
    bus = '0;
    pend = '0;
    for (int a = 0; a < 256; a++) pm[a] = boot_val(a);
    repeat (2) @(posedge i_clk);
    i_rst_n <= 1'b1;
    wait_for(0, 1'b1, 300, n);
    chk(32'(n >= 250), 32'h1, "boot length");
    mem_chk(11'h000, 256);
    for (int i = 0; i < 16; i++) begin
      n = int'(caddr);
      @(posedge i_clk);
      #1 chk({10'h0, coef}, {10'h0, pm[n]}, "core coefficient");
    end
    bus_wr(`DPMU_REG_IRQ_MASK, 32'h1);
    bus_wr(8'h0f, rnd());
    rd_chk(8'h0f, 32'h0);
    hold <= 1'b1;
    mem_wr(11'(rnd() % 200), 5);
    pb = 11'h400 | 11'(rnd() % 1000);
    mem_wr(pb, 6);
    hold <= 1'b0;
    mem_chk(pb, 6);
    for (int i = 0; i < 5; i++) begin
      r = rnd();
      sl_set(i, 8'(i * 50 + rnd() % 50), r[21:0]);
    end
    sl_req();
    sl_wait(n);
    chk(32'(n <= 5), 32'h1, "safeload latency");
    chk({31'h0, irq}, 32'h1, "irq on safeload");
    rd_chk(`DPMU_REG_STAT, 32'h0);
    rd_chk(`DPMU_REG_IRQ_STAT, 32'h1);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    for (int i = 0; i < 5; i++) mem_chk({3'h0, sa[i]}, 1);
    rd_chk(`DPMU_REG_CTRL, 32'h0);
    mem_chk(pb, 6);
    mem_wr({3'h0, sa[1]}, 1);
    r = rnd();
    sl_set(0, sa[0], r[21:0]);
    sl_req();
    // quiet bus after the request so the copy runs without interference
    repeat (8) @(posedge i_clk);
    sl_wait(n);
    mem_chk({3'h0, sa[0]}, 1);
    mem_chk({3'h0, sa[1]}, 1);
    hold <= 1'b1;
    r = rnd();
    sl_set(2, sa[2], r[21:0]);
    sl_req();
    repeat (6) rd_chk(`DPMU_REG_STAT, 32'h0);
    hold <= 1'b0;
    sl_wait(n);
    mem_chk({3'h0, sa[2]}, 1);
    sl_req();
    sl_wait(n);
    bus_rd(`DPMU_REG_IRQ_STAT, r);
    bus_wr(`DPMU_REG_CTRL, 32'h1 << `DPMU_CTRL_HALT_BIT);
    @(posedge i_clk);
    #1 chk({31'h0, rdn}, 32'h1, "ramp down");
    wait_for(0, 1'b0, RAMP + 5, n);
    chk(32'(n + 1 >= RAMP - 1 && n + 1 <= RAMP + 2), 32'h1, "ramp down length");
    rd_chk(`DPMU_REG_STAT, 32'h2);
    chk({31'h0, irq}, 32'h0, "masked irq");
    bus_wr(`DPMU_REG_IRQ_MASK, 32'h3);
    #1 chk({31'h0, irq}, 32'h1, "unmasked irq");
    rd_chk(`DPMU_REG_IRQ_STAT, 32'h2);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    rd_chk(`DPMU_REG_CTRL, 32'h1 << `DPMU_CTRL_HALT_BIT);
    mem_wr(11'h000, 64);
    mem_wr(11'h7f0, 16);
    mem_chk(11'h000, 64);
    mem_chk(11'h7f0, 16);
    for (n = 0; pc !== 10'h3f0 && n < 1100; n++) begin
      @(posedge i_clk);
      #1;
    end
    if (pc !== 10'h3f0) fail_wait("core fetch");
    for (int i = 0; i < 16; i++) begin
      n = int'(pc);
      @(posedge i_clk);
      #1 chk(instr, pg[n], "core instruction");
    end
    bus_wr(`DPMU_REG_CTRL, 32'h0);
    wait_for(1, 1'b1, 4, n);
    wait_for(1, 1'b0, RAMP + 5, n);
    chk(32'(n + 1 >= RAMP - 1 && n + 1 <= RAMP + 2), 32'h1, "ramp up length");
    chk({31'h0, run}, 32'h1, "core restarted");
    rd_chk(`DPMU_REG_STAT, 32'h0);
    print_verdict();
  end
endmodule // tb_top
